// ===== verilog/ffmd_pkg.sv
/*
  Package for the freefall/motion detector: register indices, field
  positions, reset values and the sample widths shared by the design.
  Assumes a 32-bit AHB-Lite slave with one register per aligned word.
*/
`default_nettype none
package ffmd_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CFG      = 8'h15;
  localparam logic [7:0] IDX_SRC      = 8'h16;
  localparam logic [7:0] IDX_THS      = 8'h17;
  localparam logic [7:0] IDX_COUNT    = 8'h18;
  localparam logic [7:0] IDX_THX_HIGH = 8'h73;
  localparam logic [7:0] IDX_THX_LOW  = 8'h74;
  localparam logic [7:0] IDX_THY_HIGH = 8'h75;
  localparam logic [7:0] IDX_THY_LOW  = 8'h76;
  localparam logic [7:0] IDX_THZ_HIGH = 8'h77;
  localparam logic [7:0] IDX_THZ_LOW  = 8'h78;
  localparam logic [7:0] IDX_IRQ_EN   = 8'h20;
  localparam logic [7:0] IDX_IRQ_ROUTE = 8'h21;
  localparam int          ADDR_IDX_LSB = 2;

  // configuration fields
  localparam int CFG_LATCH  = 7;
  localparam int CFG_OR_SEL = 6;
  localparam int CFG_Z_EN   = 5;
  localparam int CFG_Y_EN   = 4;
  localparam int CFG_X_EN   = 3;
  // common threshold fields
  localparam int THS_DBC_MODE = 7;
  // per-axis high register fields
  localparam int THX_XYZ_EN   = 7;
  localparam int THY_TRANS_EN = 7;
  // source register fields
  localparam int SRC_EA       = 7;
  // interrupt enable and route bit position
  localparam int IRQ_FFM_BIT  = 2;

  localparam logic [7:0]  REG_RESET  = 8'h00;
  localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;
  localparam int          SAMPLE_W   = 14;
  localparam int          AXIS_THR_W = 13;
  localparam int          CNT_W      = 8;
endpackage : ffmd_pkg
`default_nettype wire

// ===== verilog/ffmd_detect.sv
/*
  Freefall/motion detector with AHB-Lite register slave.
  Assumes acceleration samples and their valid strobe come from logic on hclk,
  one strobe per new output sample; hready is the single slave's hreadyout.
*/
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module ffmd_detect (
  // clock and reset
  input  wire logic                             hclk,
  input  wire logic                             hresetn,
  // ahb-lite slave
  input  wire logic                             hsel,
  input  wire logic [31:0]                      haddr,
  input  wire logic [1:0]                       htrans,
  input  wire logic                             hwrite,
  input  wire logic [2:0]                       hsize,
  input  wire logic [31:0]                      hwdata,
  input  wire logic                             hready,
  output logic      [31:0]                      hrdata,
  output logic                                  hreadyout,
  output logic                                  hresp,
  // acceleration samples
  input  wire logic                             sample_valid,
  input  wire logic signed [ffmd_pkg::SAMPLE_W-1:0] accel_x,
  input  wire logic signed [ffmd_pkg::SAMPLE_W-1:0] accel_y,
  input  wire logic signed [ffmd_pkg::SAMPLE_W-1:0] accel_z,
  // status and interrupts
  output logic                                  event_active,
  output logic                                  irq_int1,
  output logic                                  irq_int2
);

  typedef struct packed {
    logic [7:0]  cfg;
    logic [7:0]  ths;
    logic [7:0]  count;
    logic [7:0]  thx_h;
    logic [7:0]  thx_l;
    logic [7:0]  thy_h;
    logic [7:0]  thy_l;
    logic [7:0]  thz_h;
    logic [7:0]  thz_l;
    logic [7:0]  irq_en;
    logic [7:0]  irq_route;
    logic        ea;
    logic [5:0]  flags;
    logic [ffmd_pkg::CNT_W-1:0] dbc;
    logic        rd_pend;
    logic        wr_pend;
    logic [7:0]  idx;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        int1;
    logic        int2;
  } ffmd_state_t;

  ffmd_state_t st_ff;
  ffmd_state_t nxt_st;

  // absolute value of a signed sample; fits since the result is unsigned
  function automatic logic [ffmd_pkg::SAMPLE_W-1:0] mag_of(
    input logic signed [ffmd_pkg::SAMPLE_W-1:0] s);
    mag_of = s[ffmd_pkg::SAMPLE_W-1] ? ffmd_pkg::SAMPLE_W'(-s) : s;
  endfunction : mag_of

  // select axis threshold: common 7-bit or own 13-bit
  function automatic logic [ffmd_pkg::SAMPLE_W-1:0] thr_of(
    input logic xyz_en, input logic [7:0] ths, input logic [7:0] hi,
    input logic [7:0] lo);
    if (xyz_en)
      thr_of = ffmd_pkg::SAMPLE_W'({hi[6:0], lo[7:2]});
    else
      thr_of = ffmd_pkg::SAMPLE_W'(ths[6:0]);
  endfunction : thr_of

  function automatic logic [31:0] rd_mux(input ffmd_state_t s);
    logic [7:0] v;
    v = ffmd_pkg::REG_RESET;
    case (s.idx)
      ffmd_pkg::IDX_CFG:       v = s.cfg;
      ffmd_pkg::IDX_SRC:       v = {s.ea, 1'b0, s.flags};
      ffmd_pkg::IDX_THS:       v = s.ths;
      ffmd_pkg::IDX_COUNT:     v = s.count;
      ffmd_pkg::IDX_THX_HIGH:  v = s.thx_h;
      ffmd_pkg::IDX_THX_LOW:   v = s.thx_l;
      ffmd_pkg::IDX_THY_HIGH:  v = s.thy_h;
      ffmd_pkg::IDX_THY_LOW:   v = s.thy_l;
      ffmd_pkg::IDX_THZ_HIGH:  v = s.thz_h;
      ffmd_pkg::IDX_THZ_LOW:   v = s.thz_l;
      ffmd_pkg::IDX_IRQ_EN:    v = s.irq_en;
      ffmd_pkg::IDX_IRQ_ROUTE: v = s.irq_route;
      default:                 v = ffmd_pkg::REG_RESET;
    endcase
    rd_mux = {24'h00_0000, v};
  endfunction : rd_mux

  logic                          xyz_en;
  logic                          or_sel;
  logic                          latch_en;
  logic                          dbc_clear_mode;
  logic [2:0]                    axis_en;
  logic [ffmd_pkg::SAMPLE_W-1:0] thr [3];
  logic [ffmd_pkg::SAMPLE_W-1:0] mag [3];
  logic [2:0]                    neg;
  logic [2:0]                    below;
  logic [2:0]                    above;
  logic [2:0]                    hit;
  logic                          cond;
  logic [5:0]                    flags_live;
  logic [ffmd_pkg::CNT_W-1:0]    dbc_step;
  logic                          ea_live;
  logic                          addr_ok;
  logic                          rd_clr;

  assign xyz_en         = st_ff.thx_h[ffmd_pkg::THX_XYZ_EN];
  assign or_sel         = st_ff.cfg[ffmd_pkg::CFG_OR_SEL];
  assign latch_en       = st_ff.cfg[ffmd_pkg::CFG_LATCH];
  assign dbc_clear_mode = st_ff.ths[ffmd_pkg::THS_DBC_MODE];
  assign axis_en        = {st_ff.cfg[ffmd_pkg::CFG_Z_EN], st_ff.cfg[ffmd_pkg::CFG_Y_EN],
                           st_ff.cfg[ffmd_pkg::CFG_X_EN]};

  always_comb begin
    thr[0] = thr_of(xyz_en, st_ff.ths, st_ff.thx_h, st_ff.thx_l);
    thr[1] = thr_of(xyz_en, st_ff.ths, st_ff.thy_h, st_ff.thy_l);
    thr[2] = thr_of(xyz_en, st_ff.ths, st_ff.thz_h, st_ff.thz_l);
    mag[0] = mag_of(accel_x);
    mag[1] = mag_of(accel_y);
    mag[2] = mag_of(accel_z);
    neg    = {accel_z[ffmd_pkg::SAMPLE_W-1], accel_y[ffmd_pkg::SAMPLE_W-1],
              accel_x[ffmd_pkg::SAMPLE_W-1]};
    for (int i = 0; i < 3; i++) begin
      below[i] = mag[i] < thr[i];
      above[i] = mag[i] > thr[i];
      hit[i]   = axis_en[i] & (or_sel ? above[i] : below[i]);
    end
    // no enabled axis means no event in either mode
    if (or_sel)
      cond = |hit;
    else
      cond = (axis_en != 3'b000) && (&(~axis_en | below));
    flags_live = {hit[2], neg[2], hit[1], neg[1], hit[0], neg[0]};
  end

  // debounce step is the same whichever threshold source is active
  always_comb begin
    if (cond) begin
      if (st_ff.dbc < st_ff.count)
        dbc_step = st_ff.dbc + ffmd_pkg::CNT_W'(1);
      else
        dbc_step = ffmd_pkg::CNT_W'(st_ff.count);
    end else if (dbc_clear_mode) begin
      dbc_step = '0;
    end else if (st_ff.dbc != '0) begin
      dbc_step = st_ff.dbc - ffmd_pkg::CNT_W'(1);
    end else begin
      dbc_step = '0;
    end
    ea_live = (dbc_step == st_ff.count) && (cond || (st_ff.count != '0));
  end

  assign addr_ok = hsel && htrans[1] && hready;
  assign rd_clr  = st_ff.rd_pend && (st_ff.idx == ffmd_pkg::IDX_SRC) && latch_en;

  always_comb begin
    nxt_st           = st_ff;
    nxt_st.hresp     = 1'b0;
    nxt_st.hreadyout = 1'b1;
    nxt_st.wr_pend   = 1'b0;
    nxt_st.rd_pend   = 1'b0;
    // address phase: reads take one wait state so data comes from a flop
    if (addr_ok) begin
      nxt_st.idx     = haddr[ffmd_pkg::ADDR_IDX_LSB +: 8];
      nxt_st.wr_pend = hwrite;
      nxt_st.rd_pend = !hwrite;
      if (!hwrite)
        nxt_st.hreadyout = 1'b0;
    end
    if (st_ff.rd_pend)
      nxt_st.hrdata = rd_mux(st_ff);
    if (st_ff.wr_pend) begin
      case (st_ff.idx)
        ffmd_pkg::IDX_CFG:       nxt_st.cfg       = hwdata[7:0];
        ffmd_pkg::IDX_THS:       nxt_st.ths       = hwdata[7:0];
        ffmd_pkg::IDX_COUNT:     nxt_st.count     = hwdata[7:0];
        ffmd_pkg::IDX_THX_HIGH:  nxt_st.thx_h     = hwdata[7:0];
        ffmd_pkg::IDX_THX_LOW:   nxt_st.thx_l     = hwdata[7:0];
        ffmd_pkg::IDX_THY_HIGH:  nxt_st.thy_h     = hwdata[7:0];
        ffmd_pkg::IDX_THY_LOW:   nxt_st.thy_l     = hwdata[7:0];
        ffmd_pkg::IDX_THZ_HIGH:  nxt_st.thz_h     = hwdata[7:0];
        ffmd_pkg::IDX_THZ_LOW:   nxt_st.thz_l     = hwdata[7:0];
        ffmd_pkg::IDX_IRQ_EN:    nxt_st.irq_en    = hwdata[7:0];
        ffmd_pkg::IDX_IRQ_ROUTE: nxt_st.irq_route = hwdata[7:0];
        default:                 nxt_st.cfg       = st_ff.cfg;
      endcase
    end
    // read clear first so a same-cycle set wins
    if (rd_clr) begin
      nxt_st.ea    = 1'b0;
      nxt_st.flags = '0;
    end
    if (sample_valid) begin
      nxt_st.dbc = dbc_step;
      if (latch_en) begin
        if (ea_live)
          nxt_st.ea = 1'b1;
        if (!(st_ff.ea && !rd_clr))
          nxt_st.flags = flags_live;
      end else begin
        nxt_st.ea    = ea_live;
        nxt_st.flags = flags_live;
      end
    end
    nxt_st.int1 = nxt_st.ea && st_ff.irq_en[ffmd_pkg::IRQ_FFM_BIT]
                  && st_ff.irq_route[ffmd_pkg::IRQ_FFM_BIT];
    nxt_st.int2 = nxt_st.ea && st_ff.irq_en[ffmd_pkg::IRQ_FFM_BIT]
                  && !st_ff.irq_route[ffmd_pkg::IRQ_FFM_BIT];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff           <= '0;
      st_ff.hreadyout <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hrdata       = st_ff.hrdata;
  assign hreadyout    = st_ff.hreadyout;
  assign hresp        = st_ff.hresp;
  assign event_active = st_ff.ea;
  assign irq_int1     = st_ff.int1;
  assign irq_int2     = st_ff.int2;

  // assertions and covers
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_ea_set;
    sample_valid && ea_live |=> event_active;
  endproperty
  a_ea_set: assert property (p_ea_set) else $error("event flag not set");

  property p_src_read;
    st_ff.rd_pend && st_ff.idx == ffmd_pkg::IDX_SRC |=>
      hreadyout && hrdata[31:8] == 24'h00_0000 && !hrdata[6]
      && hrdata[7] == $past(st_ff.ea);
  endproperty
  a_src_read: assert property (p_src_read) else $error("bad source read");

  property p_live_flags;
    sample_valid && !latch_en |=> st_ff.flags == $past(flags_live);
  endproperty
  a_live_flags: assert property (p_live_flags) else $error("live flags wrong");

  property p_irq;
    ##1 (irq_int1 == (event_active && $past(st_ff.irq_en[2] && st_ff.irq_route[2])))
        && (irq_int2 == (event_active && $past(st_ff.irq_en[2] && !st_ff.irq_route[2])));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt gating wrong");

  property p_dbc_clear;
    sample_valid && !cond && dbc_clear_mode |=> st_ff.dbc == '0;
  endproperty
  a_dbc_clear: assert property (p_dbc_clear) else $error("counter not cleared");

  property p_dbc_dec;
    sample_valid && !cond && !dbc_clear_mode && st_ff.dbc != '0
      |=> st_ff.dbc == $past(st_ff.dbc) - ffmd_pkg::CNT_W'(1);
  endproperty
  a_dbc_dec: assert property (p_dbc_dec) else $error("counter not decremented");

  property p_common_thr;
    !xyz_en |-> thr[1] == ffmd_pkg::SAMPLE_W'(st_ff.ths[6:0]);
  endproperty
  a_common_thr: assert property (p_common_thr) else $error("common threshold");

  property p_axis_thr;
    xyz_en |-> thr[2] == ffmd_pkg::SAMPLE_W'({st_ff.thz_h[6:0], st_ff.thz_l[7:2]});
  endproperty
  a_axis_thr: assert property (p_axis_thr) else $error("axis threshold");

  property p_freefall;
    !or_sel && cond |-> (axis_en & below) == axis_en && axis_en != 3'b000;
  endproperty
  a_freefall: assert property (p_freefall) else $error("freefall combine");

  property p_motion;
    or_sel && cond |-> (axis_en & above) != 3'b000;
  endproperty
  a_motion: assert property (p_motion) else $error("motion combine");

  property p_freeze;
    latch_en && event_active && !rd_clr ##1 latch_en |-> $stable(st_ff.flags);
  endproperty
  a_freeze: assert property (p_freeze) else $error("latched flags moved");

  property p_cap;
    sample_valid && cond |=> st_ff.dbc <= $past(st_ff.count);
  endproperty
  a_cap: assert property (p_cap) else $error("counter above count");

  property p_ea_follow;
    sample_valid && !latch_en && !ea_live |=> !event_active;
  endproperty
  a_ea_follow: assert property (p_ea_follow) else $error("event flag not dropped");

  property p_read_clear;
    rd_clr && !sample_valid |=> !event_active && st_ff.flags == 6'h00;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read did not clear");

  property p_ea_sticky;
    latch_en && event_active && !rd_clr |=> event_active;
  endproperty
  a_ea_sticky: assert property (p_ea_sticky) else $error("latched flag dropped");

  property p_src_ro;
    st_ff.wr_pend && st_ff.idx == ffmd_pkg::IDX_SRC && !sample_valid && !rd_clr
      |=> $stable(st_ff.ea) && $stable(st_ff.flags);
  endproperty
  a_src_ro: assert property (p_src_ro) else $error("source register written");

  property p_dbc_floor;
    sample_valid && !cond && !dbc_clear_mode && st_ff.dbc == '0 |=> st_ff.dbc == '0;
  endproperty
  a_dbc_floor: assert property (p_dbc_floor) else $error("counter below zero");

  property p_dbc_hold;
    !sample_valid |=> $stable(st_ff.dbc);
  endproperty
  a_dbc_hold: assert property (p_dbc_hold) else $error("counter moved without sample");

  property p_dbc_inc;
    sample_valid && cond && st_ff.dbc < st_ff.count
      |=> st_ff.dbc == $past(st_ff.dbc) + ffmd_pkg::CNT_W'(1);
  endproperty
  a_dbc_inc: assert property (p_dbc_inc) else $error("counter not incremented");

  property p_axis_off;
    sample_valid && !latch_en && !axis_en[0] |=> !st_ff.flags[1];
  endproperty
  a_axis_off: assert property (p_axis_off) else $error("disabled axis flagged");

  property p_ths_hold;
    !(st_ff.wr_pend && st_ff.idx == ffmd_pkg::IDX_THS) |=> $stable(st_ff.ths);
  endproperty
  a_ths_hold: assert property (p_ths_hold) else $error("threshold changed");

  c_motion: cover property (or_sel && sample_valid && ea_live);
  c_freefall: cover property (!or_sel && sample_valid && ea_live);
  c_read_clear: cover property (rd_clr && event_active);
  c_decrement: cover property (sample_valid && !cond && !dbc_clear_mode && st_ff.dbc > 8'h01);

endmodule : ffmd_detect
`default_nettype wire

// ===== test/ffmd_sample_src.sv
/*
  Sample source model: one valid pulse per requested sample.
  Assumes the bench raises send for one hclk cycle per sample.
*/
`timescale 1ns/1ps
`default_nettype none
module ffmd_sample_src (
  // clock and reset
  input  wire logic                                  hclk,
  input  wire logic                                  hresetn,
  // request from the bench
  input  wire logic                                  send,
  input  wire logic signed [ffmd_pkg::SAMPLE_W-1:0] sx,
  input  wire logic signed [ffmd_pkg::SAMPLE_W-1:0] sy,
  input  wire logic signed [ffmd_pkg::SAMPLE_W-1:0] sz,
  // sample bus
  output logic                                       sample_valid,
  output logic signed      [ffmd_pkg::SAMPLE_W-1:0] accel_x,
  output logic signed      [ffmd_pkg::SAMPLE_W-1:0] accel_y,
  output logic signed      [ffmd_pkg::SAMPLE_W-1:0] accel_z
);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sample_valid <= 1'b0;
      accel_x      <= '0;
      accel_y      <= '0;
      accel_z      <= '0;
    end else if (send) begin
      sample_valid <= 1'b1;
      accel_x      <= sx;
      accel_y      <= sy;
      accel_z      <= sz;
    end else begin
      // data not held between samples
      sample_valid <= 1'b0;
      accel_x      <= ~accel_x;
      accel_y      <= ~accel_y;
      accel_z      <= ~accel_z;
    end
  end
endmodule : ffmd_sample_src
`default_nettype wire

// ===== test/ffmd_detect_tb_top.sv
/*
  Self-checking bench for the freefall/motion detector.
  Assumes the design's own assertions; bench is host and sample source.
*/
`timescale 1ns/1ps
`default_nettype none
module ffmd_detect_tb_top;
  logic        hclk, hresetn, hsel, hwrite, send;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout, hresp, sample_valid, event_active, irq_int1, irq_int2;
  wire logic   hready;
  logic signed [ffmd_pkg::SAMPLE_W-1:0] accel_x, accel_y, accel_z, sx, sy, sz;
  logic [7:0]  cfg, ths, cnt, irq_en, irq_rt, rd;
  logic [7:0]  hi [3];
  logic [7:0]  lo [3];
  logic [7:0]  idx_list [13];
  int          err_total, tests_run, mcnt;
  integer      seed;
  assign hready = hreadyout;
  ffmd_detect ffmd_detect_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sample_valid(sample_valid),
    .accel_x(accel_x), .accel_y(accel_y), .accel_z(accel_z), .event_active(event_active),
    .irq_int1(irq_int1), .irq_int2(irq_int2));
  ffmd_sample_src ffmd_sample_src_inst (.hclk(hclk), .hresetn(hresetn), .send(send),
    .sx(sx), .sy(sy), .sz(sz), .sample_valid(sample_valid), .accel_x(accel_x),
    .accel_y(accel_y), .accel_z(accel_z));
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  initial begin
    #5000000;
    $display("unexpected watchdog expected finish seen timeout");
    err_total++;
    give_verdict();
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask : chk
  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    mcnt = 0;
  endtask : do_reset
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [7:0] rv);
    int n;
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize  <= 3'b010;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    if (n >= 64) chk("bus handshake", 8'h01, 8'h00);
    chk("hresp", 8'h00, {7'h00, hresp});
    chk("hrdata upper", 8'h00, {7'h00, |hrdata[31:8]});
    rv = hrdata[7:0];
  endtask : bus
  task automatic wr_chk(input logic [7:0] idx, input logic [7:0] v);
    bus(1'b1, idx, v, rd);
    bus(1'b0, idx, 8'h00, rd);
    chk("register readback", v, rd);
  endtask : wr_chk
  function automatic logic signed [13:0] rnd();
    return 14'($random(seed) % 300);
  endfunction : rnd
  // expected source byte; advances the debounce counter model
  function automatic logic [7:0] step(input logic signed [13:0] x, y, z);
    logic [12:0] t;
    logic [2:0]  p, en;
    logic signed [13:0] s [3];
    logic        cond, ev;
    int          a;
    s[0] = x;
    s[1] = y;
    s[2] = z;
    en = {cfg[5], cfg[4], cfg[3]};
    for (int i = 0; i < 3; i++) begin
      t = hi[0][7] ? {hi[i][6:0], lo[i][7:2]} : {6'h00, ths[6:0]};
      a = s[i];
      if (a < 0) a = -a;
      p[i] = cfg[6] ? (a > t) : (a < t);
    end
    cond = (en != 3'b000) && (cfg[6] ? |(p & en) : &(p | ~en));
    if (cond) mcnt = (mcnt < cnt) ? mcnt + 1 : cnt;
    else if (ths[7]) mcnt = 0;
    else if (mcnt > 0) mcnt--;
    ev = (mcnt == cnt) && (cond || cnt != 0);
    return {ev, 1'b0, en[2] & p[2], z[13], en[1] & p[1], y[13], en[0] & p[0], x[13]};
  endfunction : step
  task automatic push(input logic signed [13:0] x, y, z);
    sx   <= x;
    sy   <= y;
    sz   <= z;
    send <= 1'b1;
    @(posedge hclk);
    send <= 1'b0;
    @(posedge hclk);
    #1;
  endtask : push
  task automatic sample_chk(input logic signed [13:0] x, y, z);
    logic [7:0] e;
    e = step(x, y, z);
    push(x, y, z);
    chk("event_active", {7'h00, e[7]}, {7'h00, event_active});
    chk("irq_int1", {7'h00, e[7] & irq_en[2] & irq_rt[2]}, {7'h00, irq_int1});
    chk("irq_int2", {7'h00, e[7] & irq_en[2] & ~irq_rt[2]}, {7'h00, irq_int2});
    @(posedge hclk);
    bus(1'b0, ffmd_pkg::IDX_SRC, 8'h00, rd);
    chk("source", e, rd);
  endtask : sample_chk
  task automatic setup();
    wr_chk(ffmd_pkg::IDX_CFG, cfg);
    wr_chk(ffmd_pkg::IDX_THS, ths);
    wr_chk(ffmd_pkg::IDX_COUNT, cnt);
    wr_chk(ffmd_pkg::IDX_IRQ_EN, irq_en);
    wr_chk(ffmd_pkg::IDX_IRQ_ROUTE, irq_rt);
    for (int i = 0; i < 3; i++) begin
      wr_chk(8'(ffmd_pkg::IDX_THX_HIGH + 2 * i), hi[i]);
      wr_chk(8'(ffmd_pkg::IDX_THX_LOW + 2 * i), lo[i]);
    end
  endtask : setup
  initial begin
    seed = 53;
    {hresetn, hsel, hwrite, send, htrans, hsize} = '0;
    {haddr, hwdata, sx, sy, sz} = '0;
    {err_total, tests_run} = '0;
    idx_list = '{8'h15, 8'h16, 8'h17, 8'h18, 8'h73, 8'h74, 8'h75, 8'h76, 8'h77, 8'h78,
                 8'h20, 8'h21, 8'h40};
    do_reset();
    foreach (idx_list[i]) begin
      bus(1'b0, idx_list[i], 8'h00, rd);
      chk("reset value", 8'h00, rd);
    end
    bus(1'b1, ffmd_pkg::IDX_SRC, 8'hFF, rd);
    bus(1'b0, ffmd_pkg::IDX_SRC, 8'h00, rd);
    chk("source after write", 8'h00, rd);
    bus(1'b1, 8'h40, 8'hFF, rd);
    bus(1'b0, 8'h40, 8'h00, rd);
    chk("unmapped readback", 8'h00, rd);
    for (int k = 0; k < 16; k++) begin
      cfg = 8'($random(seed)) & 8'h7F;
      ths = 8'($random(seed));
      cnt = 8'($random(seed)) & 8'h03;
      irq_en = 8'($random(seed));
      irq_rt = 8'($random(seed));
      for (int i = 0; i < 3; i++) begin
        hi[i] = 8'($random(seed)) & 8'h03;
        lo[i] = 8'($random(seed));
      end
      hi[0][7] = k[0];
      setup();
      if (k == 0) sample_chk(14'sd32, -14'sd31, 14'sd31);
      for (int n = 0; n < 25; n++) sample_chk(rnd(), rnd(), rnd());
      do_reset();
    end
    cfg = 8'hC8;
    ths = 8'h0A;
    cnt = 8'h00;
    {irq_en, irq_rt} = '0;
    // common threshold for the latched case
    hi[0] = 8'h00;
    setup();
    push(14'sd50, 14'sd0, 14'sd0);
    chk("latched event_active", 8'h01, {7'h00, event_active});
    @(posedge hclk);
    push(-14'sd5, 14'sd0, 14'sd0);
    @(posedge hclk);
    bus(1'b0, ffmd_pkg::IDX_SRC, 8'h00, rd);
    chk("latched source", 8'h82, rd);
    chk("event_active after read", 8'h00, {7'h00, event_active});
    bus(1'b0, ffmd_pkg::IDX_SRC, 8'h00, rd);
    chk("source after clear", 8'h00, rd);
    push(-14'sd60, 14'sd0, 14'sd0);
    @(posedge hclk);
    bus(1'b0, ffmd_pkg::IDX_SRC, 8'h00, rd);
    chk("relatched source", 8'h83, rd);
    give_verdict();
  end
endmodule : ffmd_detect_tb_top
`default_nettype wire
